// ===== logic/pcs_consts.svh
// Constants for the program counter, return stack and indirect address block
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_PC_W        13
`define PCS_LATCH_W     5
`define PCS_STK_DEPTH   8
`define PCS_SP_W        3
`define PCS_EA_W        9
`define PCS_OFF_LOW     12'h000
`define PCS_OFF_LATCH   12'h004
`define PCS_OFF_PTR     12'h008
`define PCS_OFF_BANK    12'h00c
`define PCS_RST_PC      13'h0000
`define PCS_RST_LATCH   5'h00
`define PCS_RST_PTR     8'h00
`define PCS_IRQ_VECTOR  13'h0004
`define PCS_IND_PORT    7'h00
`endif

// ===== logic/pcs_pkg.sv
// Types shared by the program counter, return stack and indirect address block
`include "pcs_consts.svh"
package pcs_pkg;
    // One instruction step as seen by the decoder
    typedef struct packed {
        logic        irq;
        logic        call;
        logic        jump;
        logic        ret;
        logic        wr_low;
        logic        step;
        logic [7:0]  low_data;
        logic [10:0] target;
    } pcs_core_op_t;

    // Indirect data port access and pointer update from the decoder
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
        logic       ptr_we;
        logic [7:0] ptr_wdata;
    } pcs_ind_req_t;

    // Request to the data memory
    typedef struct packed {
        logic [`PCS_EA_W-1:0] addr;
        logic                 re;
        logic                 we;
        logic [7:0]           wdata;
    } pcs_dmem_t;

    typedef struct packed {
        logic [`PCS_PC_W-1:0]                          pc;
        logic [`PCS_LATCH_W-1:0]                       latch;
        logic [7:0]                                    ptr;
        logic                                          bank;
        logic [`PCS_STK_DEPTH-1:0][`PCS_PC_W-1:0]      stk;
        logic [`PCS_SP_W-1:0]                          sp;
        pcs_dmem_t                                     dm;
        logic                                          rd_pend;
        logic                                          rd_self;
        logic [7:0]                                    rdata;
        logic                                          rvalid;
        logic [31:0]                                   prdata;
        logic                                          pslverr;
    } pcs_state_t;
endpackage : pcs_pkg

// ===== logic/pcs_pc_stack.sv
// Program counter, circular return stack and indirect data addressing
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_pc_stack
    import pcs_pkg::*;
#(
    parameter int PADDR_W = 12
) (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire pcs_core_op_t       core_op,
    output logic [`PCS_PC_W-1:0]    pc_out,
    input  wire pcs_ind_req_t       ind_req,
    output pcs_dmem_t               dmem,
    input  wire logic [7:0]         dmem_rdata,
    output logic [7:0]              ind_rdata,
    output logic                    ind_rvalid
);

    pcs_state_t s_q;
    pcs_state_t s_d;

    // Address decode shared by the read and the write path
    function automatic logic [4:0] reg_hit(input logic [PADDR_W-1:0] a);
        logic [4:0] h;
        h      = 5'h00;
        h[0]   = (a == PADDR_W'(`PCS_OFF_LOW));
        h[1]   = (a == PADDR_W'(`PCS_OFF_LATCH));
        h[2]   = (a == PADDR_W'(`PCS_OFF_PTR));
        h[3]   = (a == PADDR_W'(`PCS_OFF_BANK));
        h[4]   = ~|h[3:0];
        return h;
    endfunction : reg_hit

    logic [4:0]            hit;
    logic                  apb_setup;
    logic                  apb_wr;
    logic                  push;
    logic                  pop;
    logic                  ptr_self;
    logic [`PCS_SP_W-1:0]  sp_dec;
    logic [`PCS_PC_W-1:0]  ret_addr;

    // Zero wait state slave: read data was latched during the setup cycle
    assign hit       = reg_hit(paddr);
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite & ~hit[4] & pstrb[0];
    assign pready    = 1'b1;
    assign prdata    = s_q.prdata;
    assign pslverr   = s_q.pslverr;

    // Interrupt outranks call and jump, which outrank return; a lost return must not pop
    assign push      = core_op.irq | core_op.call;
    assign pop       = core_op.ret & ~push & ~core_op.jump;
    assign sp_dec    = s_q.sp - `PCS_SP_W'(1);
    assign ptr_self  = (s_q.ptr[6:0] == `PCS_IND_PORT);
    assign ret_addr  = s_q.pc + `PCS_PC_W'(1);

    assign pc_out     = s_q.pc;
    assign dmem       = s_q.dm;
    assign ind_rdata  = s_q.rdata;
    assign ind_rvalid = s_q.rvalid;

    // Next state of the whole block
    always_comb begin
        s_d = s_q;

        // Program counter load, highest priority first
        if (core_op.irq) begin
            s_d.pc = `PCS_IRQ_VECTOR;
        end else if (core_op.call | core_op.jump) begin
            s_d.pc = {s_q.latch[4:3], core_op.target};
        end else if (pop) begin
            s_d.pc = s_q.stk[sp_dec];
        end else if (core_op.wr_low) begin
            s_d.pc = {s_q.latch, core_op.low_data};
        end else if (apb_wr & hit[0]) begin
            s_d.pc = {s_q.latch, pwdata[7:0]};
        end else if (core_op.step) begin
            s_d.pc = ret_addr;
        end

        // Interrupt resumes the instruction it preempted; a call returns past itself
        if (push) begin
            s_d.stk[s_q.sp] = core_op.irq ? s_q.pc : ret_addr;
            s_d.sp          = s_q.sp + `PCS_SP_W'(1);
        end else if (pop) begin
            s_d.sp = sp_dec;
        end

        // Latch is touched by software only, never by the stack
        if (apb_wr & hit[1]) begin
            s_d.latch = pwdata[`PCS_LATCH_W-1:0];
        end
        if (ind_req.ptr_we) begin
            s_d.ptr = ind_req.ptr_wdata;
        end else if (apb_wr & hit[2]) begin
            s_d.ptr = pwdata[7:0];
        end
        if (apb_wr & hit[3]) begin
            s_d.bank = pwdata[0];
        end

        // Indirect access: one cycle to memory, data back one cycle later
        s_d.dm.re   = 1'b0;
        s_d.dm.we   = 1'b0;
        s_d.rvalid  = 1'b0;
        if (ind_req.rd | ind_req.wr) begin
            s_d.dm.addr  = {s_q.bank, s_q.ptr};
            s_d.dm.wdata = ind_req.wdata;
            s_d.dm.re    = ind_req.rd & ~ptr_self;
            s_d.dm.we    = ind_req.wr & ~ind_req.rd & ~ptr_self;
        end
        s_d.rd_pend = ind_req.rd;
        s_d.rd_self = ptr_self;
        if (s_q.rd_pend) begin
            s_d.rdata  = s_q.rd_self ? 8'h00 : dmem_rdata;
            s_d.rvalid = 1'b1;
        end

        // Read data formed in setup; stack pointer has no address at all
        if (apb_setup) begin
            s_d.prdata  = 32'h0000_0000;
            s_d.pslverr = hit[4];
            if (!pwrite) begin
                case (1'b1)
                    hit[0]:  s_d.prdata[7:0] = s_q.pc[7:0];
                    hit[1]:  s_d.prdata[`PCS_LATCH_W-1:0] = s_q.latch;
                    hit[2]:  s_d.prdata[7:0] = s_q.ptr;
                    hit[3]:  s_d.prdata[0] = s_q.bank;
                    default: s_d.prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q         <= '0;
            s_q.pc      <= `PCS_RST_PC;
            s_q.latch   <= `PCS_RST_LATCH;
            s_q.ptr     <= `PCS_RST_PTR;
        end else begin
            s_q <= s_d;
        end
    end

    // Stack slot written by the push one cycle back, kept for the push checks
    logic [`PCS_SP_W-1:0] sp_at_push;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sp_at_push <= '0;
        end else begin
            sp_at_push <= s_q.sp;
        end
    end

    property p_low_load;
        @(posedge ref_clk) disable iff (!nrst)
        (core_op.wr_low & ~core_op.irq & ~core_op.call & ~core_op.jump & ~core_op.ret)
            |=> (s_q.pc == {$past(s_q.latch), $past(core_op.low_data)});
    endproperty
    a_low_load: assert property (p_low_load) else $error("low byte load wrong");

    property p_jump;
        @(posedge ref_clk) disable iff (!nrst)
        ((core_op.jump | core_op.call) & ~core_op.irq)
            |=> (s_q.pc == {$past(s_q.latch[4:3]), $past(core_op.target)});
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_call_push;
        @(posedge ref_clk) disable iff (!nrst)
        (core_op.call & ~core_op.irq)
            |=> (s_q.stk[sp_at_push] == $past(s_q.pc) + `PCS_PC_W'(1));
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_pop;
        @(posedge ref_clk) disable iff (!nrst)
        pop |=> (s_q.pc == $past(s_q.stk[sp_dec])) && (s_q.sp == $past(sp_dec));
    endproperty
    a_pop: assert property (p_pop) else $error("pop wrong");

    property p_latch_keep;
        @(posedge ref_clk) disable iff (!nrst)
        ((push | pop) & ~(apb_wr & hit[1])) |=> $stable(s_q.latch);
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("latch moved");

    property p_wrap;
        @(posedge ref_clk) disable iff (!nrst)
        (push && s_q.sp == `PCS_SP_W'(7)) |=> (s_q.sp == `PCS_SP_W'(0));
    endproperty
    a_wrap: assert property (p_wrap) else $error("stack did not wrap");

    sequence s_self_rd;
        ind_req.rd && ptr_self;
    endsequence

    sequence s_zero_back;
        ##2 (ind_rvalid && ind_rdata == 8'h00);
    endsequence

    property p_self_rd;
        @(posedge ref_clk) disable iff (!nrst)
        s_self_rd |-> s_zero_back;
    endproperty
    a_self_rd: assert property (p_self_rd) else $error("self read not zero");

    property p_self_wr;
        @(posedge ref_clk) disable iff (!nrst)
        (ind_req.wr && ptr_self) |=> !dmem.we;
    endproperty
    a_self_wr: assert property (p_self_wr) else $error("self write stored");

    property p_eff_addr;
        @(posedge ref_clk) disable iff (!nrst)
        (ind_req.rd | ind_req.wr) |=> (dmem.addr == {$past(s_q.bank), $past(s_q.ptr)});
    endproperty
    a_eff_addr: assert property (p_eff_addr) else $error("effective address wrong");

    // Counter sits at zero for as long as reset is held
    property p_reset_pc;
        @(posedge ref_clk)
        !nrst |-> (pc_out == `PCS_RST_PC);
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("pc not zero in reset");

    // Plain step counts across all thirteen bits, carry included
    property p_step;
        @(posedge ref_clk) disable iff (!nrst)
        (core_op.step & ~push & ~core_op.jump & ~core_op.ret & ~core_op.wr_low
            & ~(apb_wr & hit[0])) |=> (s_q.pc == $past(s_q.pc) + `PCS_PC_W'(1));
    endproperty
    a_step: assert property (p_step) else $error("step wrong");

    // Bus write of the low byte moves all thirteen bits at once
    property p_apb_low;
        @(posedge ref_clk) disable iff (!nrst)
        (apb_wr & hit[0] & ~push & ~core_op.jump & ~core_op.ret & ~core_op.wr_low)
            |=> (s_q.pc == {$past(s_q.latch), $past(pwdata[7:0])});
    endproperty
    a_apb_low: assert property (p_apb_low) else $error("bus low write wrong");

    // Low byte read shows the counter as it stood at the setup edge
    property p_low_read;
        @(posedge ref_clk) disable iff (!nrst)
        (apb_setup & ~pwrite & hit[0]) |=> (prdata == {24'h00_0000, $past(s_q.pc[7:0])});
    endproperty
    a_low_read: assert property (p_low_read) else $error("low byte read wrong");

    // Stack pointer and upper counter bits have no address, so the bus is refused
    property p_unmapped;
        @(posedge ref_clk) disable iff (!nrst)
        (apb_setup & hit[4]) |=> (pslverr && prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access taken");

    // Latch loads only its five bits from the bus
    property p_latch_wr;
        @(posedge ref_clk) disable iff (!nrst)
        (apb_wr & hit[1]) |=> (s_q.latch == $past(pwdata[`PCS_LATCH_W-1:0]));
    endproperty
    a_latch_wr: assert property (p_latch_wr) else $error("latch write wrong");

    // Interrupt saves the counter it preempted and goes to the vector
    sequence s_irq_taken;
        core_op.irq;
    endsequence

    property p_irq_push;
        @(posedge ref_clk) disable iff (!nrst)
        s_irq_taken |=> (s_q.stk[sp_at_push] == $past(s_q.pc))
            && (s_q.pc == `PCS_IRQ_VECTOR);
    endproperty
    a_irq_push: assert property (p_irq_push) else $error("interrupt push wrong");

    // A pop from an empty stack wraps silently; no flag exists to report it
    property p_underflow;
        @(posedge ref_clk) disable iff (!nrst)
        (pop && s_q.sp == `PCS_SP_W'(0)) |=> (s_q.sp == `PCS_SP_W'(7));
    endproperty
    a_underflow: assert property (p_underflow) else $error("stack did not wrap down");

    // Read through the port: memory strobe next cycle, its data one cycle later
    sequence s_fetch;
        dmem.re ##1 (ind_rvalid && ind_rdata == $past(dmem_rdata));
    endsequence

    property p_ind_rd;
        @(posedge ref_clk) disable iff (!nrst)
        (ind_req.rd && !ptr_self) |=> s_fetch;
    endproperty
    a_ind_rd: assert property (p_ind_rd) else $error("indirect read wrong");

    // Write through the port hands the byte to memory for one cycle
    property p_ind_wr;
        @(posedge ref_clk) disable iff (!nrst)
        (ind_req.wr && !ind_req.rd && !ptr_self)
            |=> (dmem.we && dmem.wdata == $past(ind_req.wdata));
    endproperty
    a_ind_wr: assert property (p_ind_wr) else $error("indirect write wrong");

    // Self-pointing read never touches memory
    property p_self_no_re;
        @(posedge ref_clk) disable iff (!nrst)
        s_self_rd |=> !dmem.re;
    endproperty
    a_self_no_re: assert property (p_self_no_re) else $error("self read hit memory");

    // Pointer takes the bus byte only when the core leaves it alone
    property p_ptr_load;
        @(posedge ref_clk) disable iff (!nrst)
        (apb_wr & hit[2] & ~ind_req.ptr_we) |=> (s_q.ptr == $past(pwdata[7:0]));
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer write wrong");

endmodule : pcs_pc_stack
`default_nettype wire

// ===== verif/pcs_dmem_model.sv
// Behavioural data memory facing the indirect address port
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_dmem_model
    import pcs_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire pcs_dmem_t dmem,
    output logic [7:0]     dmem_rdata
);
    logic [7:0] mem [0:(1<<`PCS_EA_W)-1];
    logic [7:0] last_q;

    // Filled with a marker so a stray write or a stray read shows up
    initial begin
        for (int i = 0; i < (1 << `PCS_EA_W); i++) mem[i] = 8'ha5;
        last_q = 8'h00;
    end

    // Writes land on the edge that sees the strobe
    always @(posedge ref_clk) begin
        if (dmem.we === 1'b1) mem[dmem.addr] <= dmem.wdata;
        if (dmem.re === 1'b1) last_q <= mem[dmem.addr];
    end

    // Unselected bus shows the inverse of the last read, never a held value
    assign dmem_rdata = (dmem.re === 1'b1) ? mem[dmem.addr] : ~last_q;
endmodule : pcs_dmem_model
`default_nettype wire

// ===== verif/program_counter_stack_indirect_tb.sv
// Self-checking bench for the program counter, return stack and indirect port
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.svh"
module program_counter_stack_indirect_tb
    import pcs_pkg::*;
;
    logic ref_clk = 1'b0, nrst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h1;
    logic pready, pslverr, ind_rvalid, err;
    pcs_core_op_t core_op = '0;
    pcs_ind_req_t ind_req = '0;
    pcs_dmem_t dmem;
    logic [7:0] dmem_rdata, ind_rdata;
    logic [12:0] pc_out, pc, pu [0:8];
    int num_errors = 0, n_tests = 0;

    always #25 ref_clk = ~ref_clk;

    pcs_pc_stack u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .core_op(core_op), .pc_out(pc_out),
        .ind_req(ind_req), .dmem(dmem), .dmem_rdata(dmem_rdata), .ind_rdata(ind_rdata),
        .ind_rvalid(ind_rvalid));
    pcs_dmem_model u_mem (.ref_clk(ref_clk), .dmem(dmem), .dmem_rdata(dmem_rdata));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // No wait-state count is assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Core op for one cycle: f = irq, call, jump, ret
    task automatic op(input logic [3:0] f, input logic [10:0] t);
        pcs_core_op_t o;
        o = '0;
        {o.irq, o.call, o.jump, o.ret} = f;
        o.target = t;
        @(posedge ref_clk);
        core_op <= o;
        @(posedge ref_clk);
        core_op <= '0;
        #1;
    endtask : op

    // Low byte load (st = 0) or plain step (st = 1) for one cycle
    task automatic lop(input logic st, input logic [7:0] d);
        pcs_core_op_t o;
        o = '0;
        o.step = st;
        o.wr_low = ~st;
        o.low_data = d;
        @(posedge ref_clk);
        core_op <= o;
        @(posedge ref_clk);
        core_op <= '0;
        #1;
    endtask : lop

    // Indirect access; wr=1 writes d, otherwise a read whose data is returned in rd
    task automatic ind(input logic w, input logic [7:0] d);
        pcs_ind_req_t r;
        r = '0;
        r.rd = ~w; r.wr = w; r.wdata = d;
        @(posedge ref_clk);
        ind_req <= r;
        @(posedge ref_clk);
        ind_req <= '0;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            #1;
            if (ind_rvalid === 1'b1) break;
        end
        rd = {24'h0, ind_rdata};
        if (!w) chk("read valid", 32'h1, {31'h0, ind_rvalid});
    endtask : ind

    task automatic t_reset_low();
        chk("pc after reset", 32'h0, pc_out);
        apb(1'b1, `PCS_OFF_LATCH, 32'h15);
        apb(1'b1, `PCS_OFF_LOW, 32'ha7);
        #1 chk("pc after low write", 32'h15a7, pc_out);
        apb(1'b0, `PCS_OFF_LOW, 32'h0);
        chk("low byte read", 32'ha7, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
    endtask : t_reset_low

    task automatic t_call_irq();
        apb(1'b1, `PCS_OFF_LATCH, 32'h1a);
        op(4'b0010, 11'h7ff);
        chk("jump target", 32'h1fff, pc_out);
        op(4'b0100, 11'h123);
        chk("call target", 32'h1923, pc_out);
        op(4'b1000, 11'h000);
        chk("irq vector", `PCS_IRQ_VECTOR, pc_out);
        op(4'b0001, 11'h000);
        chk("irq return", 32'h1923, pc_out);
        op(4'b0001, 11'h000);
        chk("call return", 32'h0000, pc_out);
        apb(1'b0, `PCS_OFF_LATCH, 32'h0);
        chk("latch kept", 32'h1a, rd);
    endtask : t_call_irq

    // Nine pushes against eight slots: the ninth lands on the first
    task automatic t_wrap();
        apb(1'b1, `PCS_OFF_LATCH, 32'h0);
        pc = pc_out;
        for (int i = 0; i < 9; i++) begin
            pu[i] = pc + 13'h1;
            op(4'b0100, 11'(16 * (i + 1)));
            pc = 13'(16 * (i + 1));
        end
        for (int i = 8; i >= 0; i--) begin
            op(4'b0001, 11'h000);
            chk("wrapped pop", {19'h0, pu[(i == 0) ? 8 : i]}, pc_out);
        end
    endtask : t_wrap

    task automatic t_indirect();
        apb(1'b1, `PCS_OFF_BANK, 32'h1);
        apb(1'b1, `PCS_OFF_PTR, 32'h45);
        ind(1'b1, 8'h3c);
        chk("indirect store", 32'h3c, u_mem.mem[9'h145]);
        ind(1'b0, 8'h00);
        chk("indirect load", 32'h3c, rd);
        apb(1'b1, `PCS_OFF_PTR, 32'h80);
        ind(1'b1, 8'h99);
        chk("self write", 32'ha5, u_mem.mem[9'h180]);
        ind(1'b0, 8'h00);
        chk("self read", 32'h0, rd);
    endtask : t_indirect

    // Computed jump: the low byte add never carries, so software bumps the latch
    task automatic t_computed();
        apb(1'b1, `PCS_OFF_LATCH, 32'h02);
        lop(1'b0, 8'h05);
        chk("add without carry", 32'h0205, pc_out);
        apb(1'b1, `PCS_OFF_LATCH, 32'h03);
        lop(1'b0, 8'hff);
        chk("latch bumped", 32'h03ff, pc_out);
        lop(1'b1, 8'h00);
        chk("step carries", 32'h0400, pc_out);
    endtask : t_computed

    // Reset in mid-run clears the counter and the latch again
    task automatic t_reset_mid();
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        chk("pc after second reset", 32'h0, pc_out);
        apb(1'b0, `PCS_OFF_LATCH, 32'h0);
        chk("latch after second reset", 32'h0, rd);
    endtask : t_reset_mid

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Main sequence after ten cycles of reset
    initial begin
        nrst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset_low();
        t_call_irq();
        t_wrap();
        t_computed();
        t_reset_mid();
        t_indirect();
        wrap_up();
    end

    // Whole run is about 130 cycles; this cuts a hang short at 3000 cycles
    initial begin
        #(3000 * 50);
        num_errors++;
        wrap_up();
    end
endmodule : program_counter_stack_indirect_tb
`default_nettype wire
